//--- inc/link_xlat_cfg.svh
// Register offsets, field positions, reset values and sizes of the link address translator.
// Assumes a 32-bit classic Wishbone slave port with byte addressing.
`ifndef LINK_XLAT_CFG_SVH
`define LINK_XLAT_CFG_SVH
`define OFS_TX_OVERLAY     8'h00
`define OFS_RX_SELECT      8'h04
`define OFS_RID_INDEX      8'h08
`define OFS_RID_VALUE      8'h0C
`define OFS_SEG_INDEX      8'h10
`define OFS_SEG_VALUE      8'h14
`define OFS_STATUS         8'h18
`define RST_TX_OVERLAY     32'h0000_0F0F
`define RST_RX_SELECT      32'h0000_0000
`define RID_ENTRIES        32'h0000_0010
`define SEG_ENTRIES        32'h0000_0040
`define SEG_LEN_MIN        5'h08
`define SEG_LEN_MAX        5'h1B
`define BURST_FULL         9'h100
`define BURST_REDUCED      9'h040
`define POS_KEEP_LSB       0
`define POS_RID_LSB        4
`define POS_SEC_LSB        8
`define POS_SEC_ONE        12
`define POS_SEC_ZERO       13
`define POS_REDUCED        16
`define POS_SEG_LEN_LSB    0
`define POS_SEG_BASE_LSB   16
`endif

//--- inc/link_xlat_pkg.sv
// Types shared by the link address translator and its surroundings.
// Assumes one clock domain; egress structs travel on same-clock valid/ready handshakes, ingress structs on valid alone.
package link_xlat_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] len;
    logic [3:0]  requester_id;
    logic        secure;
  } egress_req_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [8:0]  len;
    logic [3:0]  requester_id;
    logic        secure;
  } egress_burst_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [8:0]  len;
    logic [7:0]  byte_en;
  } ingress_req_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  requester_id;
    logic        secure;
    logic [7:0]  byte_en;
    logic        violation;
  } ingress_out_t;
  typedef enum logic [0:0] {SPLIT_IDLE, SPLIT_RUN} split_state_t;
endpackage : link_xlat_pkg

//--- hw/link_address_translation.sv
// Address translation for a chip-to-chip memory-mapped link: egress split and overlay,
// ingress rebuild of address, requester ID and security bit, and a Wishbone register file.
// Assumes every request port is driven by logic on clk_in and that the far end keeps
// each transaction inside one mapped region.
//
// Behaviour
// RULE1: Up to 64 regions, 64 KB aligned base, power-of-two size from 512 B.
// RULE2: Regions capped at 256 MB; every packet is translated on its own.
// RULE3: Egress address: keep masked bits, overlay requester ID, then security bit.
// RULE4: Requester ID and security overlays each have 16 selectable positions.
// RULE5: On overlap security beats requester ID, which beats kept address bits.
// RULE6: Ingress security comes from one selected address bit choosing high or low value.
// RULE7: Equal high and low values give a constant security bit.
// RULE8: Sixteen 4-bit requester ID entries, indexed by selected incoming address bits.
// RULE9: Software writes the index first, then the value, upper bits zero.
// RULE10: Value register reads return the indexed requester ID entry.
// RULE11: 64-entry segment table via index and value registers, indexed by address bits.
// RULE12: Segment select also picks one of 16 low-bit keep patterns.
// RULE13: Ingress address is segment base bits 31:16 plus masked incoming address.
// RULE14: Segment sizes span 512 B to 256 MB, bases on 64 KB boundaries.
// RULE15: Over-length transactions get address bits 31:5 and byte enables zeroed.
// RULE16: The far end keeps transactions inside one region.
// RULE17: Large egress transfers split into bursts of at most 256 bytes.
// RULE18: Reduced mode limits bursts to 64 B, split at 64 B boundaries.
// RULE19: Keep-mask value 8 keeps 0x01FF_FFFF.
// RULE20: Requester position 10 means bits 29:26 on both sides.
// RULE21: Security position 9 means bit 25 on both sides.
// RULE22: Segment select 8 indexes with bits 29:24 and keeps 0x00FFFFFF.
// RULE23: Length code n means a segment of 2 to the n+1 bytes.
// RULE24: Out-of-range table index: value writes ignored, value reads return zero.
`include "link_xlat_cfg.svh"
module link_address_translation (
  // Clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          srst_in,
  // Wishbone register slave
  input  wire logic                          wb_cyc_in,
  input  wire logic                          wb_stb_in,
  input  wire logic                          wb_we_in,
  input  wire logic [7:0]                    wb_adr_in,
  input  wire logic [3:0]                    wb_sel_in,
  input  wire logic [31:0]                   wb_dat_in,
  output logic                               wb_ack_out,
  output logic [31:0]                        wb_dat_out,
  // Egress transfer request from the local master
  input  wire logic                          eg_req_valid_in,
  input  wire link_xlat_pkg::egress_req_t    eg_req_in,
  output logic                               eg_req_ready_out,
  // Egress translated bursts towards the link
  output logic                               eg_burst_valid_out,
  output link_xlat_pkg::egress_burst_t       eg_burst_out,
  input  wire logic                          eg_burst_ready_in,
  // Ingress packets from the link
  input  wire logic                          in_valid_in,
  input  wire link_xlat_pkg::ingress_req_t   in_req_in,
  output logic                               in_valid_out,
  output link_xlat_pkg::ingress_out_t        in_out_out
);

  logic [31:0]                 tx_overlay_q;
  logic [31:0]                 rx_select_q;
  logic [31:0]                 rid_index_q;
  logic [31:0]                 seg_index_q;
  logic [3:0]                  rid_table_q [16];
  logic [15:0]                 seg_base_q  [64];
  logic [4:0]                  seg_len_q   [64];
  logic                        ack_q;
  logic [31:0]                 rdata_q;
  logic                        wb_req;
  logic                        wb_wr;
  logic [31:0]                 wmask;
  logic [31:0]                 wval;
  logic                        rid_in_range;
  logic                        seg_in_range;
  logic [31:0]                 rdata_d;

  assign wb_req       = wb_cyc_in && wb_stb_in && !ack_q;
  assign wb_wr        = wb_cyc_in && wb_stb_in && wb_we_in && ack_q;
  assign wmask        = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}},
                         {8{wb_sel_in[0]}}};
  assign rid_in_range = rid_index_q < `RID_ENTRIES;
  assign seg_in_range = seg_index_q < `SEG_ENTRIES;
  assign wval         = wb_dat_in & wmask;

  // Answer every access one cycle after it is presented and drop ack the cycle after.
  // Writes land on the edge at which the master sees ack, while its request still stands.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= wb_req;
      rdata_q <= (wb_req && !wb_we_in) ? rdata_d : 32'h0000_0000;
    end
  end

  // Control registers honour byte selects.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tx_overlay_q <= `RST_TX_OVERLAY;
      rx_select_q  <= `RST_RX_SELECT;
      rid_index_q  <= 32'h0000_0000;
      seg_index_q  <= 32'h0000_0000;
    end else if (wb_wr) begin
      case (wb_adr_in)
        `OFS_TX_OVERLAY: tx_overlay_q <= (tx_overlay_q & ~wmask) | wval;
        `OFS_RX_SELECT:  rx_select_q  <= (rx_select_q & ~wmask) | wval;
        `OFS_RID_INDEX:  rid_index_q  <= (rid_index_q & ~wmask) | wval; // RULE9
        `OFS_SEG_INDEX:  seg_index_q  <= (seg_index_q & ~wmask) | wval;
        default: ;
      endcase
    end
  end

  // The tables have no reset; software loads them before enabling traffic.
  always_ff @(posedge clk_in) begin
    if (wb_wr && wb_adr_in == `OFS_RID_VALUE && wb_sel_in[0] && rid_in_range) begin // RULE24
      rid_table_q[rid_index_q[3:0]] <= wb_dat_in[3:0]; // RULE8
    end
  end

  // Length codes are clamped so a segment never leaves the 512 B to 256 MB range.
  always_ff @(posedge clk_in) begin
    if (wb_wr && wb_adr_in == `OFS_SEG_VALUE && seg_in_range) begin // RULE24
      if (wb_sel_in[3] && wb_sel_in[2]) begin
        seg_base_q[seg_index_q[5:0]] <= wb_dat_in[`POS_SEG_BASE_LSB +: 16]; // RULE11
      end
      if (wb_sel_in[0]) begin
        if (wb_dat_in[4:0] < `SEG_LEN_MIN) begin
          seg_len_q[seg_index_q[5:0]] <= `SEG_LEN_MIN; // RULE14
        end else if (wb_dat_in[4:0] > `SEG_LEN_MAX) begin
          seg_len_q[seg_index_q[5:0]] <= `SEG_LEN_MAX; // RULE2
        end else begin
          seg_len_q[seg_index_q[5:0]] <= wb_dat_in[4:0];
        end
      end
    end
  end

  // ---------------- Egress burst split ----------------
  link_xlat_pkg::split_state_t state_q;
  logic [31:0]                 cur_addr_q;
  logic [15:0]                 remain_q;
  logic [3:0]                  cur_rid_q;
  logic                        cur_sec_q;
  logic                        req_ready_q;
  logic                        bv_q;
  link_xlat_pkg::egress_burst_t burst_q;
  logic                        reduced;
  logic [8:0]                  max_len;
  logic [8:0]                  chunk;
  logic [8:0]                  blen;
  logic                        load_burst;
  logic                        last_ingress_violation_q;

  assign reduced    = rx_select_q[`POS_REDUCED];
  assign max_len    = reduced ? `BURST_REDUCED : `BURST_FULL; // RULE17 RULE18
  assign chunk      = max_len - {1'b0, cur_addr_q[7:0] & (max_len[7:0] - 8'h01)}; // RULE18
  assign blen       = (remain_q < {7'h00, chunk}) ? remain_q[8:0] : chunk;
  assign load_burst = state_q == link_xlat_pkg::SPLIT_RUN && remain_q != 16'h0000 &&
                      (!bv_q || eg_burst_ready_in);

  // Each outgoing packet is trimmed and overlaid on its own start address.
  function automatic logic [31:0] egress_addr(input logic [31:0] a, input logic [3:0] rid,
                                              input logic sec, input logic [31:0] ctl);
    logic [31:0] r;
    logic [4:0]  rpos;
    logic [4:0]  spos;
    r    = a & (32'hFFFF_FFFF >> (4'hF - ctl[`POS_KEEP_LSB +: 4])); // RULE3 RULE19
    rpos = {1'b1, ctl[`POS_RID_LSB +: 4]}; // RULE4 RULE20
    spos = {1'b1, ctl[`POS_SEC_LSB +: 4]}; // RULE21
    r    = (r & ~(32'h0000_000F << rpos)) | ({28'h000_0000, rid} << rpos); // RULE5
    r    = (r & ~(32'h0000_0001 << spos)) | ({31'h0000_0000, sec} << spos); // RULE5
    return r;
  endfunction : egress_addr

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_q     <= link_xlat_pkg::SPLIT_IDLE;
      req_ready_q <= 1'b1;
      cur_addr_q  <= 32'h0000_0000;
      remain_q    <= 16'h0000;
      cur_rid_q   <= 4'h0;
      cur_sec_q   <= 1'b0;
    end else begin
      case (state_q)
        link_xlat_pkg::SPLIT_IDLE: begin
          if (eg_req_valid_in && req_ready_q && eg_req_in.len != 16'h0000) begin
            state_q     <= link_xlat_pkg::SPLIT_RUN;
            req_ready_q <= 1'b0;
            cur_addr_q  <= eg_req_in.addr;
            remain_q    <= eg_req_in.len;
            cur_rid_q   <= eg_req_in.requester_id;
            cur_sec_q   <= eg_req_in.secure;
          end
        end
        link_xlat_pkg::SPLIT_RUN: begin
          if (load_burst) begin
            cur_addr_q <= cur_addr_q + {23'h00_0000, blen};
            remain_q   <= remain_q - {7'h00, blen}; // RULE17
          end else if (remain_q == 16'h0000 && (!bv_q || eg_burst_ready_in)) begin
            state_q     <= link_xlat_pkg::SPLIT_IDLE;
            req_ready_q <= 1'b1;
          end
        end
        default: state_q <= link_xlat_pkg::SPLIT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bv_q    <= 1'b0;
      burst_q <= '0;
    end else if (load_burst) begin
      bv_q                 <= 1'b1;
      burst_q.addr         <= egress_addr(cur_addr_q, cur_rid_q, cur_sec_q, tx_overlay_q); // RULE2
      burst_q.len          <= blen;
      burst_q.requester_id <= cur_rid_q;
      burst_q.secure       <= cur_sec_q;
    end else if (eg_burst_ready_in) begin
      bv_q <= 1'b0;
    end
  end

  // ---------------- Ingress rebuild ----------------
  logic [3:0]                  seg_sel;
  logic [4:0]                  seg_lsb;
  logic [31:0]                 seg_keep;
  logic [5:0]                  seg_idx;
  logic [31:0]                 in_off;
  logic [32:0]                 seg_size;
  logic                        too_long;
  logic [3:0]                  rid_idx;
  logic                        sec_bit;
  logic                        iv_q;
  link_xlat_pkg::ingress_out_t iout_q;
  logic [31:0]                 in_addr_ok;
  logic [31:0]                 shifted_seg;
  logic [31:0]                 shifted_rid;

  assign seg_sel     = rx_select_q[`POS_KEEP_LSB +: 4];
  assign seg_lsb     = {1'b1, seg_sel}; // RULE22
  assign seg_keep    = 32'hFFFF_FFFF >> (5'h10 - {1'b0, seg_sel}); // RULE12 RULE22
  assign shifted_seg = in_req_in.addr >> seg_lsb;
  assign seg_idx     = shifted_seg[5:0]; // RULE11
  assign in_off      = in_req_in.addr & seg_keep;
  assign seg_size    = 33'h0_0000_0001 << ({1'b0, seg_len_q[seg_idx]} + 6'h01); // RULE23
  assign too_long    = ({1'b0, in_off} + {24'h00_0000, in_req_in.len}) > seg_size; // RULE15
  assign shifted_rid = in_req_in.addr >> {1'b1, rx_select_q[`POS_RID_LSB +: 4]};
  assign rid_idx     = shifted_rid[3:0]; // RULE20
  assign sec_bit     = in_req_in.addr[{1'b1, rx_select_q[`POS_SEC_LSB +: 4]}]; // RULE21
  assign in_addr_ok  = {seg_base_q[seg_idx], 16'h0000} + in_off; // RULE13 RULE1

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      iv_q   <= 1'b0;
      iout_q <= '0;
    end else begin
      iv_q <= in_valid_in;
      if (in_valid_in) begin
        iout_q.requester_id <= rid_table_q[rid_idx]; // RULE8
        iout_q.secure       <= sec_bit ? rx_select_q[`POS_SEC_ONE]
                                       : rx_select_q[`POS_SEC_ZERO]; // RULE6 RULE7
        iout_q.violation    <= too_long;
        if (too_long) begin
          iout_q.addr    <= {27'h000_0000, in_addr_ok[4:0]}; // RULE15
          iout_q.byte_en <= 8'h00; // RULE15
        end else begin
          iout_q.addr    <= in_addr_ok;
          iout_q.byte_en <= in_req_in.byte_en;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      last_ingress_violation_q <= 1'b0;
    end else if (in_valid_in) begin
      last_ingress_violation_q <= too_long;
    end
  end

  // Read multiplexer; unmapped offsets read as zero and writes to them are dropped.
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (wb_adr_in)
      `OFS_TX_OVERLAY: rdata_d = tx_overlay_q;
      `OFS_RX_SELECT:  rdata_d = rx_select_q;
      `OFS_RID_INDEX:  rdata_d = rid_index_q;
      `OFS_RID_VALUE:  rdata_d = rid_in_range ? {28'h000_0000, rid_table_q[rid_index_q[3:0]]}
                                              : 32'h0000_0000; // RULE10 RULE24
      `OFS_SEG_INDEX:  rdata_d = seg_index_q;
      `OFS_SEG_VALUE:  rdata_d = seg_in_range ? {seg_base_q[seg_index_q[5:0]], 11'h000,
                                                 seg_len_q[seg_index_q[5:0]]}
                                              : 32'h0000_0000; // RULE24
      `OFS_STATUS:     rdata_d = {30'h0000_0000, state_q == link_xlat_pkg::SPLIT_RUN,
                                  last_ingress_violation_q};
      default:         rdata_d = 32'h0000_0000;
    endcase
  end

  assign wb_ack_out         = ack_q;
  assign wb_dat_out         = rdata_q;
  assign eg_req_ready_out   = req_ready_q;
  assign eg_burst_valid_out = bv_q;
  assign eg_burst_out       = burst_q;
  assign in_valid_out       = iv_q;
  assign in_out_out         = iout_q;

  // ---------------- Assertions ----------------
  logic [3:0] exp_rid;
  assign exp_rid = rid_table_q[rid_idx];

  property p_ack_pulse;
    @(posedge clk_in) disable iff (srst_in) ack_q |=> !ack_q;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles"); // RULE9

  property p_ack_answer;
    @(posedge clk_in) disable iff (srst_in) wb_req |=> ack_q;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("access not answered"); // RULE10

  property p_burst_len;
    @(posedge clk_in) disable iff (srst_in)
      bv_q |-> burst_q.len != 9'h000 && burst_q.len <= max_len;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst length out of range"); // RULE17

  property p_burst_boundary;
    @(posedge clk_in) disable iff (srst_in)
      load_burst && reduced |-> ({1'b0, cur_addr_q[5:0]} + blen) <= `BURST_REDUCED;
  endproperty
  a_burst_boundary: assert property (p_burst_boundary) else $error("burst crosses 64 B"); // RULE18

  property p_sec_overlay;
    @(posedge clk_in) disable iff (srst_in)
      $rose(bv_q) |-> burst_q.addr[{1'b1, tx_overlay_q[`POS_SEC_LSB +: 4]}] == burst_q.secure;
  endproperty
  a_sec_overlay: assert property (p_sec_overlay) else $error("security overlay lost"); // RULE5

  property p_ingress_latency;
    @(posedge clk_in) disable iff (srst_in) in_valid_in |=> in_valid_out ##1 !in_valid_out
      or in_valid_out;
  endproperty
  a_ingress_latency: assert property (p_ingress_latency) else $error("ingress late"); // RULE2

  property p_rid_lookup;
    @(posedge clk_in) disable iff (srst_in)
      in_valid_in |=> iout_q.requester_id == $past(exp_rid);
  endproperty
  a_rid_lookup: assert property (p_rid_lookup) else $error("requester ID mismatch"); // RULE8

  property p_violation_clear;
    @(posedge clk_in) disable iff (srst_in)
      iv_q && iout_q.violation |-> iout_q.byte_en == 8'h00 && iout_q.addr[31:5] == 27'h0;
  endproperty
  a_violation_clear: assert property (p_violation_clear) else $error("violation leaked"); // RULE15

  property p_sec_constant;
    @(posedge clk_in) disable iff (srst_in)
      in_valid_in && rx_select_q[`POS_SEC_ONE] == rx_select_q[`POS_SEC_ZERO]
      |=> iout_q.secure == $past(rx_select_q[`POS_SEC_ONE]);
  endproperty
  a_sec_constant: assert property (p_sec_constant) else $error("security not constant"); // RULE7

  property p_ready_drop;
    @(posedge clk_in) disable iff (srst_in)
      eg_req_valid_in && req_ready_q && eg_req_in.len != 16'h0000 |=> !req_ready_q;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready stayed high"); // RULE17

endmodule : link_address_translation

//--- verification/link_far_end_model.sv
// Far-end sink model for the translated egress bursts of the link address translator.
// Assumes the burst handshake is sampled on the rising edge of clk_in.
module link_far_end_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic srst_in,
  // Pacing and handshake
  input  wire logic slow_in,
  input  wire logic burst_valid_in,
  output logic      burst_ready_out
);
  logic [1:0] pace_q;

  // A slow sink takes one beat in four, so a held burst has to survive stalls.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pace_q <= 2'h0;
    end else if (burst_valid_in) begin
      pace_q <= pace_q + 2'h1;
    end
  end

  assign burst_ready_out = !slow_in || (pace_q == 2'h3);
endmodule : link_far_end_model

//--- verification/link_address_translation_tb.sv
// Self-checking bench for the link address translator: registers, egress, ingress.
// Assumes one 100 MHz clock, a far-end sink model and tables loaded before traffic.
module link_address_translation_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                          clk_in   = 1'b0;
  logic                          srst_in  = 1'b1;
  logic                          cyc      = 1'b0;
  logic                          stb      = 1'b0;
  logic                          we       = 1'b0;
  logic [7:0]                    adr      = 8'h00;
  logic [3:0]                    sel      = 4'hF;
  logic [31:0]                   wdat     = 32'h0000_0000;
  logic                          ack;
  logic [31:0]                   rdat;
  logic                          eg_valid = 1'b0;
  link_xlat_pkg::egress_req_t    eg_req   = '0;
  logic                          eg_ready;
  logic                          bv;
  link_xlat_pkg::egress_burst_t  burst;
  logic                          br;
  logic                          slow     = 1'b0;
  logic                          in_valid = 1'b0;
  link_xlat_pkg::ingress_req_t   in_req   = '0;
  logic                          out_valid;
  link_xlat_pkg::ingress_out_t   out;
  link_xlat_pkg::egress_burst_t  seen_q[$];
  int                            miscompares = 0;
  int                            n_tests     = 0;

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  link_address_translation i_link_address_translation (
    .clk_in(clk_in), .srst_in(srst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_ack_out(ack), .wb_dat_out(rdat),
    .eg_req_valid_in(eg_valid), .eg_req_in(eg_req), .eg_req_ready_out(eg_ready),
    .eg_burst_valid_out(bv), .eg_burst_out(burst), .eg_burst_ready_in(br),
    .in_valid_in(in_valid), .in_req_in(in_req), .in_valid_out(out_valid), .in_out_out(out));

  link_far_end_model i_link_far_end_model (
    .clk_in(clk_in), .srst_in(srst_in), .slow_in(slow), .burst_valid_in(bv),
    .burst_ready_out(br));

  always @(posedge clk_in) begin
    if (bv === 1'b1 && br === 1'b1) begin
      seen_q.push_back(burst);
    end
  end

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Classic single Wishbone cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    @(posedge clk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) chk("wishbone ack", 64'h1, 64'h0);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, r);
    chk(what, {32'h0, e}, {32'h0, r});
  endtask : rd_chk

  task automatic eg_send(input logic [31:0] a, input logic [15:0] len, input logic [3:0] rid,
                         input logic sec, input int nb);
    int n;
    seen_q.delete();
    @(posedge clk_in);
    eg_valid <= 1'b1; eg_req <= '{addr: a, len: len, requester_id: rid, secure: sec};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (eg_ready !== 1'b1 && n < 50);
    eg_valid <= 1'b0;
    n = 0;
    while (seen_q.size() < nb && n < 400) begin
      @(posedge clk_in);
      n++;
    end
    repeat (20) @(posedge clk_in);
    chk("burst count", nb, seen_q.size());
  endtask : eg_send

  task automatic chk_b(input int i, input logic [31:0] a, input logic [8:0] len,
                       input logic [3:0] rid, input logic sec);
    chk("egress burst", {a, len, rid, sec}, (i < seen_q.size()) ? seen_q[i] : '0);
  endtask : chk_b

  task automatic in_send(input logic [31:0] a, input logic [8:0] len, input logic [7:0] be,
                         input logic [45:0] exp);
    @(posedge clk_in);
    in_valid <= 1'b1; in_req <= '{addr: a, len: len, byte_en: be};
    @(posedge clk_in);
    in_valid <= 1'b0;
    @(posedge clk_in);
    chk("ingress valid", 64'h1, {63'h0, out_valid});
    chk("ingress result", {18'h0, exp}, {18'h0, out});
  endtask : in_send

  task automatic t_regs;
    rd_chk("overlay reset", 8'h00, 32'h0000_0F0F);
    rd_chk("select reset", 8'h04, 32'h0000_0000);
    rd_chk("unmapped read", 8'h1C, 32'h0000_0000);
  endtask : t_regs

  task automatic t_egress;
    wr(8'h00, 32'h0000_09A8);
    eg_send(32'h0408_0050, 16'h0010, 4'h7, 1'b1, 1);
    chk_b(0, 32'h1E08_0050, 9'h010, 4'h7, 1'b1);
    wr(8'h00, 32'h0000_000F);
    eg_send(32'hFFFF_FFFF, 16'h0001, 4'h0, 1'b1, 1);
    chk_b(0, 32'hFFF1_FFFF, 9'h001, 4'h0, 1'b1);
  endtask : t_egress

  // The sink stalls, so every held burst has to stand until it is taken.
  task automatic t_split;
    slow <= 1'b1;
    eg_send(32'h0000_0080, 16'd600, 4'h0, 1'b0, 3);
    chk_b(0, 32'h0000_0080, 9'h080, 4'h0, 1'b0);
    chk_b(1, 32'h0000_0100, 9'h100, 4'h0, 1'b0);
    chk_b(2, 32'h0000_0200, 9'h0D8, 4'h0, 1'b0);
    wr(8'h04, 32'h0001_0000);
    eg_send(32'h0000_0020, 16'd100, 4'h0, 1'b0, 3);
    chk_b(0, 32'h0000_0020, 9'h020, 4'h0, 1'b0);
    chk_b(1, 32'h0000_0040, 9'h040, 4'h0, 1'b0);
    chk_b(2, 32'h0000_0080, 9'h004, 4'h0, 1'b0);
    slow <= 1'b0;
  endtask : t_split

  task automatic t_ingress;
    wr(8'h04, 32'h0000_19A8);
    wr(8'h08, 32'h0000_0007);
    wr(8'h0C, 32'h0000_0003);
    wr(8'h10, 32'h0000_001E);
    wr(8'h14, 32'h1234_0013);
    rd_chk("requester entry", 8'h0C, 32'h0000_0003);
    in_send(32'h1E08_0050, 9'h008, 8'hFF, {32'h123C_0050, 4'h3, 1'b1, 8'hFF, 1'b0});
    in_send(32'h1E0F_FFE0, 9'h020, 8'hFF, {32'h1243_FFE0, 4'h3, 1'b1, 8'hFF, 1'b0});
    in_send(32'h1E0F_FFF0, 9'h020, 8'hFF, {32'h0000_0010, 4'h3, 1'b1, 8'h00, 1'b1});
    rd_chk("last violation", 8'h18, 32'h0000_0001);
    wr(8'h04, 32'h0000_10A8);
    in_send(32'h1E08_0050, 9'h008, 8'h0F, {32'h123C_0050, 4'h3, 1'b0, 8'h0F, 1'b0});
    in_send(32'h1E09_0050, 9'h008, 8'h0F, {32'h123D_0050, 4'h3, 1'b1, 8'h0F, 1'b0});
    wr(8'h04, 32'h0000_30A8);
    in_send(32'h1E08_0050, 9'h008, 8'h0F, {32'h123C_0050, 4'h3, 1'b1, 8'h0F, 1'b0});
    wr(8'h08, 32'h0000_0010);
    wr(8'h0C, 32'h0000_0005);
    rd_chk("out of range entry", 8'h0C, 32'h0000_0000);
    wr(8'h08, 32'h0000_0007);
    rd_chk("entry kept", 8'h0C, 32'h0000_0003);
  endtask : t_ingress

  initial begin
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    t_regs();
    t_egress();
    t_split();
    t_ingress();
    give_verdict();
  end

  // The whole run needs a few hundred cycles; this limit only catches a hang.
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    give_verdict();
  end
endmodule : link_address_translation_tb
